// file: pwsd_core.sv
`timescale 1ns/1ps
module pwsd_core (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    input  wire logic        shutdown_pin_n_i,
    input  wire logic        comparator_one_i,
    input  wire logic        comparator_two_i,
    output logic             output_a_o,
    output logic             output_a_oe_o,
    output logic             output_b_o,
    output logic             output_b_oe_o,
    output logic             output_c_o,
    output logic             output_c_oe_o,
    output logic             output_d_o,
    output logic             output_d_oe_o
);
    import pwsd_pkg::*;

    logic [7:0]  ctrl;
    logic [7:0]  shdn;
    logic [7:0]  cfg;
    logic [7:0]  period;
    logic [7:0]  duty;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [1:0]  tcy_cnt;
    logic [7:0]  pwm_cnt;
    logic        running;
    logic        db_a;
    logic        db_b;
    logic        req;
    logic        wr;
    logic        cond;
    logic        tick;
    logic        period_start;
    logic        flag;
    logic        wr_shdn;
    logic        ev_shut;
    logic        ev_restart;
    logic        shut;
    logic        raw;
    logic [DB_W-1:0] db_count;

    // Decode on the word address; the two byte-lane bits are ignored.
    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] reg_adr);
        return adr[7:2] == reg_adr[7:2];
    endfunction : hit

    // Returns {oe, level}: pins outside the pin enable are released.
    function automatic logic [1:0] pin_next(input logic en, input logic sd,
                                           input logic [1:0] pss,
                                           input logic lvl);
        if (!en) begin
            return 2'b00;
        end else if (sd) begin
            return pss[PSS_TRI] ? 2'b00 : {1'b1, pss[0]};
        end else begin
            return {1'b1, lvl};
        end
    endfunction : pin_next

    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr      = req && wb_we_i && wb_sel_i[0];
    assign wr_shdn = wr && hit(wb_adr_i, ADR_SHDN);
    assign flag    = shdn[SHDN_FLAG];

    // External levels cross into this clock through two flops each.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
        end else begin
            sync1 <= {!shutdown_pin_n_i, comparator_two_i, comparator_one_i};
            sync2 <= sync1;
        end
    end

    // The source level is used, not an edge, so a held fault stays shut.
    assign cond = |(sync2 & shdn[6:4]);

    assign tick         = tcy_cnt == TCY_LAST;
    assign period_start = tick && pwm_cnt == period;
    assign raw          = running && pwm_cnt < duty;
    assign db_count     = cfg[CFG_HALF] ? ctrl[DB_W-1:0] : '0;
    assign shut         = flag || cond;
    assign ev_shut      = !flag && (cond || (wr_shdn && wb_dat_i[SHDN_FLAG]));
    assign ev_restart   = period_start && !running && !shut && cfg[CFG_PWM_EN];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tcy_cnt <= '0;
            pwm_cnt <= '0;
        end else begin
            tcy_cnt <= tick ? '0 : tcy_cnt + 1'b1;
            if (!cfg[CFG_PWM_EN] || period_start) begin
                pwm_cnt <= '0;
            end else if (tick) begin
                pwm_cnt <= pwm_cnt + 1'b1;
            end
        end
    end

    // A restart waits for the period boundary so the first pulse is whole.
    always_ff @(posedge clk_i) begin
        if (rst_i || shut || !cfg[CFG_PWM_EN]) begin
            running <= 1'b0;
        end else if (period_start) begin
            running <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl   <= CTRL_RESET;
            cfg    <= CFG_RESET;
            period <= PERIOD_RESET;
            duty   <= DUTY_RESET;
        end else if (wr) begin
            if (hit(wb_adr_i, ADR_CTRL)) begin
                ctrl <= wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, ADR_CFG)) begin
                cfg <= wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, ADR_PERIOD)) begin
                period <= wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, ADR_DUTY)) begin
                duty <= wb_dat_i[7:0];
            end
        end
    end

    // The live condition wins over any write, so the flag cannot be cleared
    // while the fault stands.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shdn <= SHDN_RESET;
        end else begin
            if (wr_shdn) begin
                shdn[6:0] <= wb_dat_i[6:0];
            end
            if (cond) begin
                shdn[SHDN_FLAG] <= 1'b1;
            end else if (wr_shdn) begin
                shdn[SHDN_FLAG] <= wb_dat_i[SHDN_FLAG];
            end else if (ctrl[CTRL_RESTART]) begin
                shdn[SHDN_FLAG] <= 1'b0;
            end
        end
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq_o    <= 1'b0;
        end else begin
            if (wr && hit(wb_adr_i, ADR_IRQ_MASK)) begin
                irq_mask <= wb_dat_i[1:0];
            end
            for (int i = 0; i < 2; i++) begin
                if (wr && hit(wb_adr_i, ADR_IRQ_STAT) && wb_dat_i[i]) begin
                    irq_stat[i] <= 1'b0;
                end
            end
            if (ev_shut) begin
                irq_stat[IRQ_SHUT] <= 1'b1;
            end
            if (ev_restart) begin
                irq_stat[IRQ_RESTART] <= 1'b1;
            end
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // Ack is registered, so every access costs exactly one wait state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= '0;
            if (req && !wb_we_i) begin
                unique case (1'b1)
                    hit(wb_adr_i, ADR_CTRL):     wb_dat_o[7:0] <= ctrl;
                    hit(wb_adr_i, ADR_SHDN):     wb_dat_o[7:0] <= shdn;
                    hit(wb_adr_i, ADR_CFG):      wb_dat_o[7:0] <= cfg;
                    hit(wb_adr_i, ADR_PERIOD):   wb_dat_o[7:0] <= period;
                    hit(wb_adr_i, ADR_DUTY):     wb_dat_o[7:0] <= duty;
                    hit(wb_adr_i, ADR_IRQ_STAT): wb_dat_o[1:0] <= irq_stat;
                    hit(wb_adr_i, ADR_IRQ_MASK): wb_dat_o[1:0] <= irq_mask;
                    hit(wb_adr_i, ADR_STATE):    wb_dat_o[1:0] <= {cond, running};
                    default:                     wb_dat_o      <= '0;
                endcase
            end
        end
    end

    // Each leg waits its own dead band, so neither switch turns on early.
    pwsd_deadband u_db_a (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (tick),
        .in_i    (raw),
        .count_i (db_count),
        .out_o   (db_a)
    );

    pwsd_deadband u_db_b (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (tick),
        .in_i    (running && !raw),
        .count_i (db_count),
        .out_o   (db_b)
    );

    // The forced state is one clock behind the fault: pins come from flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {output_a_oe_o, output_a_o} <= 2'b00;
            {output_b_oe_o, output_b_o} <= 2'b00;
            {output_c_oe_o, output_c_o} <= 2'b00;
            {output_d_oe_o, output_d_o} <= 2'b00;
        end else begin
            {output_a_oe_o, output_a_o} <=
                pin_next(cfg[CFG_PIN_LSB], shut, shdn[3:2], db_a);
            {output_b_oe_o, output_b_o} <=
                pin_next(cfg[CFG_PIN_LSB+1], shut, shdn[1:0], db_b);
            {output_c_oe_o, output_c_o} <=
                pin_next(cfg[CFG_PIN_LSB+2], shut, shdn[3:2], db_a);
            {output_d_oe_o, output_d_o} <=
                pin_next(cfg[CFG_PIN_LSB+3], shut, shdn[1:0], db_b);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic pair_ac_ok;
    assign pair_ac_ok = shdn[3] ? !output_a_oe_o
                      : (output_a_o == shdn[2] || !cfg[CFG_PIN_LSB]);

    sequence seq_fault_gone;
        flag && !cond && !wr_shdn;
    endsequence

    flag_set_a: assert property (cond |=> flag)
        else $error("Shutdown condition did not set the event flag.");
    level_hold_a: assert property (cond [*2] |-> pair_ac_ok)
        else $error("Pins left their shutdown state during a fault.");
    pss_drive_a: assert property
        ((cond && cfg[CFG_PIN_LSB] && shdn[3:2] == 2'b00) [*2]
         |-> output_a_oe_o && !output_a_o)
        else $error("Pair drive-zero state not applied.");
    write_block_a: assert property
        ((cond && wr_shdn && !wb_dat_i[SHDN_FLAG]) |=> flag)
        else $error("Flag cleared by software during a fault.");
    resume_edge_a: assert property
        ($rose(running) |-> $past(period_start))
        else $error("Output resumed away from a period start.");
    auto_clear_a: assert property
        ((seq_fault_gone and ctrl[CTRL_RESTART]) |=> !flag)
        else $error("Auto restart did not clear the flag.");
    no_auto_a: assert property
        ((seq_fault_gone and !ctrl[CTRL_RESTART]) |=> flag)
        else $error("Flag cleared without auto restart.");
    src_off_a: assert property
        ((shdn[6:4] == 3'h0 && !flag && !wr_shdn) |=> !flag)
        else $error("Disabled source select still shut down.");
    force_a: assert property
        ((wr_shdn && wb_dat_i[SHDN_FLAG]) |=> flag ##1 !running)
        else $error("Software forced shutdown did not take.");
endmodule : pwsd_core

// file: pwsd_pkg.sv
package pwsd_pkg;
    localparam int          DATA_W        = 8;
    localparam logic [7:0]  ADR_CTRL      = 8'h00;
    localparam logic [7:0]  ADR_SHDN      = 8'h04;
    localparam logic [7:0]  ADR_CFG       = 8'h08;
    localparam logic [7:0]  ADR_PERIOD    = 8'h0c;
    localparam logic [7:0]  ADR_DUTY      = 8'h10;
    localparam logic [7:0]  ADR_IRQ_STAT  = 8'h14;
    localparam logic [7:0]  ADR_IRQ_MASK  = 8'h18;
    localparam logic [7:0]  ADR_STATE     = 8'h1c;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  SHDN_RESET    = 8'h00;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [7:0]  PERIOD_RESET  = 8'hff;
    localparam logic [7:0]  DUTY_RESET    = 8'h00;
    localparam int          CTRL_RESTART  = 7;
    localparam int          SHDN_FLAG     = 7;
    localparam int          CFG_PWM_EN    = 0;
    localparam int          CFG_HALF      = 1;
    localparam int          CFG_PIN_LSB   = 4;
    localparam int          IRQ_SHUT      = 0;
    localparam int          IRQ_RESTART   = 1;
    localparam int          SRC_CMP1      = 0;
    localparam int          SRC_CMP2      = 1;
    localparam int          SRC_PIN       = 2;
    localparam int          PSS_TRI       = 1;
    localparam int          DB_W          = 7;
    localparam real         CLK_NS        = 10.0;
    localparam real         TCY_NS        = 40.0;
    localparam int          TCY_CLKS      = int'(TCY_NS / CLK_NS);
    localparam logic [1:0]  TCY_LAST      = 2'(TCY_CLKS - 1);
endpackage : pwsd_pkg

// file: pwsd_deadband.sv
`timescale 1ns/1ps
module pwsd_deadband (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     tick_i,
    input  wire logic                     in_i,
    input  wire logic [pwsd_pkg::DB_W-1:0] count_i,
    output logic                          out_o
);
    import pwsd_pkg::*;

    logic [DB_W-1:0] cnt;

    // Only the inactive-to-active edge waits; the active-to-inactive edge
    // follows at once so the other switch is never held on late.
    always_ff @(posedge clk_i) begin
        if (rst_i || !in_i) begin
            out_o <= 1'b0;
            cnt   <= '0;
        end else if (!out_o) begin
            // A count lowered in mid-wait still releases the edge.
            if (cnt >= count_i) begin
                out_o <= 1'b1;
            end else if (tick_i) begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    fall_fast_a: assert property (!in_i |=> !out_o)
        else $error("Delayed output did not drop with its input.");
    rise_count_a: assert property
        ((in_i && !out_o && cnt >= count_i) |=> out_o)
        else $error("Delayed output missed its programmed edge.");
    early_rise_a: assert property
        ((!out_o && in_i && cnt < count_i) |=> !out_o || !in_i)
        else $error("Delayed output rose before its count expired.");
    zero_delay_a: assert property
        ((count_i == '0 && in_i && !out_o) |=> out_o)
        else $error("Zero delay count still delayed the output.");
endmodule : pwsd_deadband

// file: pwsd_bridge_model.sv
`timescale 1ns/1ps
// Half-bridge switch drivers: pad 1 drives the high side, pad 0 the low side.
// The driver inputs have no pull, so a released pin wanders every cycle.
module pwsd_bridge_model (
    input  wire logic       clk_i,
    input  wire logic       arm_i,
    input  wire logic [1:0] pin_i,
    input  wire logic [1:0] oe_i,
    output logic      [1:0] pad_o,
    output int              shoot_o
);
    logic wander = 1'b0;
    initial shoot_o = 0;
    always @(posedge clk_i) begin
        wander <= ~wander;
    end
    assign pad_o[1] = oe_i[1] ? pin_i[1] : wander;
    assign pad_o[0] = oe_i[0] ? pin_i[0] : ~wander;
    // Both switches on at once shorts the bridge supply.
    always @(posedge clk_i) begin
        if (arm_i && (pad_o === 2'b11)) begin
            shoot_o <= shoot_o + 1;
        end
    end
endmodule : pwsd_bridge_model

// file: pwm_shutdown_restart_deadband_bench.sv
`timescale 1ns/1ps
module pwm_shutdown_restart_deadband_bench;
    import pwsd_pkg::*;
    logic        clk_i        = 1'b0;
    logic        rst_i        = 1'b1;
    logic        req          = 1'b0;
    logic        we           = 1'b0;
    logic [7:0]  adr          = 8'h00;
    logic [31:0] wdat         = 32'h0;
    logic        pin_n        = 1'b1;
    logic        cmp1         = 1'b0;
    logic        cmp2         = 1'b0;
    logic        arm          = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    logic [3:0]  lvl;
    logic [3:0]  oe;
    logic [1:0]  pad;
    int          shoot;
    int          mismatches   = 0;
    int          total_checks = 0;
    int          cyc_n        = 0;
    logic [31:0] seed         = 32'd76;
    logic [7:0]  exp_q[$];

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;

    pwsd_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
        .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .shutdown_pin_n_i(pin_n), .comparator_one_i(cmp1),
        .comparator_two_i(cmp2), .output_a_o(lvl[3]),
        .output_a_oe_o(oe[3]), .output_b_o(lvl[2]), .output_b_oe_o(oe[2]),
        .output_c_o(lvl[1]), .output_c_oe_o(oe[1]), .output_d_o(lvl[0]),
        .output_d_oe_o(oe[0]));

    pwsd_bridge_model u_bridge (.clk_i(clk_i), .arm_i(arm),
        .pin_i(lvl[3:2]), .oe_i(oe[3:2]), .pad_o(pad), .shoot_o(shoot));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            mismatches++;
            end_sim();
        end
        req <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd

    // Read data is judged at the ack edge, while the request is still held.
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                check("unexpected read", 32'h1, 32'h0);
            end else begin
                check("read data", {24'h0, exp_q.pop_front()}, rdat);
            end
        end
    end

    // Sampled 1 ns after the edge so the registered pins have settled.
    task automatic wait_pin(input int i, input logic v, output int t);
        int n;
        n = 0;
        while (lvl[i] !== v && n < 300) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (lvl[i] !== v) begin
            mismatches++;
            end_sim();
        end
        t = cyc_n;
    endtask : wait_pin

    task automatic src(input int s, input logic on);
        if (s == 0) begin
            cmp1 <= on;
        end else if (s == 1) begin
            cmp2 <= on;
        end else begin
            pin_n <= ~on;
        end
    endtask : src

    task automatic shut_chk(input logic [3:0] p);
        logic [3:0] m;
        logic [3:0] e;
        m = {~p[3], ~p[1], ~p[3], ~p[1]};
        e = m & {p[2], p[0], p[2], p[0]};
        check("pin enables", {28'h0, m}, {28'h0, oe});
        check("pin levels", {28'h0, e}, {28'h0, lvl & m});
    endtask : shut_chk

    initial begin
        int         t1, t2, t3, t4, t5, ph, n, lo, hi;
        int         dbs[4];
        logic [7:0] v;
        logic       sel;
        logic       ok;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (n = 0; n < 9; n++) begin
            v = (n == 3) ? PERIOD_RESET : 8'h00;
            rd(8'(n * 4), v);
        end
        v = 8'(rnd());
        bus(1'b1, ADR_CTRL, v);
        rd(ADR_CTRL, v);
        bus(1'b1, ADR_CTRL, 8'h00);
        bus(1'b1, ADR_CFG, 8'hf1);
        bus(1'b1, ADR_PERIOD, 8'h03);
        bus(1'b1, ADR_DUTY, 8'h02);
        bus(1'b1, ADR_IRQ_MASK, 8'h01);
        $display("register test done");
        for (int c = 0; c < 8; c++) begin
            for (int s = 0; s < 3; s++) begin
                v = {1'b0, 3'(c), 4'(rnd())};
                sel = c[s];
                bus(1'b1, ADR_SHDN, v);
                src(s, 1'b1);
                repeat (5) @(posedge clk_i);
                rd(ADR_SHDN, {sel, v[6:0]});
                if (sel) shut_chk(v[3:0]);
                if (sel) rd(ADR_STATE, 8'h02);
                bus(1'b1, ADR_SHDN, v);
                rd(ADR_SHDN, {sel, v[6:0]});
                if (sel) shut_chk(v[3:0]);
                src(s, 1'b0);
                repeat (5) @(posedge clk_i);
                rd(ADR_SHDN, {sel, v[6:0]});
                bus(1'b1, ADR_SHDN, v);
                rd(ADR_SHDN, v);
            end
        end
        #1;
        check("irq raised", 32'h1, {31'h0, irq});
        bus(1'b1, ADR_IRQ_STAT, 8'h03);
        repeat (2) @(posedge clk_i);
        #1;
        check("irq cleared", 32'h0, {31'h0, irq});
        $display("shutdown source test done");
        wait_pin(3, 1'b0, t1);
        wait_pin(3, 1'b1, t1);
        ph = t1 % 16;
        bus(1'b1, ADR_SHDN, 8'h80);
        repeat (40) @(posedge clk_i);
        shut_chk(4'h0);
        rd(ADR_SHDN, 8'h80);
        bus(1'b1, ADR_SHDN, 8'h00);
        wait_pin(3, 1'b1, t2);
        check("restart phase", 32'(ph), 32'(t2 % 16));
        bus(1'b1, ADR_CTRL, 8'h80);
        bus(1'b1, ADR_SHDN, 8'h10);
        cmp1 <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd(ADR_SHDN, 8'h90);
        cmp1 <= 1'b0;
        wait_pin(3, 1'b1, t2);
        check("auto restart phase", 32'(ph), 32'(t2 % 16));
        rd(ADR_SHDN, 8'h10);
        bus(1'b1, ADR_SHDN, 8'h00);
        rd(ADR_IRQ_STAT, 8'h03);
        $display("restart test done");
        bus(1'b1, ADR_CFG, 8'hf3);
        bus(1'b1, ADR_PERIOD, 8'h0f);
        bus(1'b1, ADR_DUTY, 8'h08);
        arm <= 1'b1;
        // Counts stay below 7 so the delay never swallows a 32 clock pulse.
        dbs = '{0, 1, 5, 2 + int'(rnd() % 5)};
        foreach (dbs[k]) begin
            n = dbs[k];
            bus(1'b1, ADR_CTRL, 8'(n));
            repeat (140) @(posedge clk_i);
            wait_pin(3, 1'b1, t1);
            wait_pin(3, 1'b0, t1);
            wait_pin(2, 1'b1, t2);
            wait_pin(2, 1'b0, t3);
            wait_pin(3, 1'b1, t4);
            wait_pin(3, 1'b0, t5);
            lo = (n == 0) ? 0 : 4 * n - 3;
            hi = (n == 0) ? 0 : 4 * n + 1;
            ok = t2 - t1 >= lo && t2 - t1 <= hi;
            check("b rise delay", 32'h1, {31'h0, ok});
            ok = t4 - t3 >= lo && t4 - t3 <= hi;
            check("a rise delay", 32'h1, {31'h0, ok});
            check("a fall spacing", 32'd64, 32'(t5 - t1));
        end
        check("shoot through", 32'h0, 32'(shoot));
        arm <= 1'b0;
        $display("dead band test done");
        check("pending reads", 32'h0, 32'(exp_q.size()));
        end_sim();
    end
endmodule : pwm_shutdown_restart_deadband_bench
